/* pkg/wide_timer_pkg.sv */
// constants shared by the wide timer control block and its prescaler
package wide_timer_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam int              ADDR_W        = 16;
  localparam logic [11:0]     IDX_COMMON    = 12'hd01;
  localparam logic [11:0]     IDX_CONTROL   = 12'hd02;
  localparam logic [11:0]     IDX_RELOAD_LO = 12'hd10;
  localparam logic [11:0]     IDX_RELOAD_HI = 12'hd11;
  localparam logic [11:0]     IDX_CAPT_LO   = 12'hd12;
  localparam logic [11:0]     IDX_CAPT_HI   = 12'hd13;
  localparam logic [11:0]     IDX_PORT_OUT  = 12'hd14;

  // ==========================================================================
  // wide_timer_control fields
  localparam int              CTL_RUN       = 7;
  localparam int              CTL_SINGLE    = 6;
  localparam int              CTL_TIMEOUT   = 5;
  localparam int              CTL_PRESC_HI  = 4;
  localparam int              CTL_PRESC_LO  = 3;
  localparam int              CTL_CAP_IE    = 2;
  localparam int              CTL_TO_IE     = 1;
  localparam int              CTL_PIN_SEL   = 0;

  // common_function_control fields
  localparam int              CMN_MODE      = 7;
  localparam int              CMN_EDGE_HI   = 5;
  localparam int              CMN_EDGE_LO   = 4;
  localparam int              CMN_INIT_OUT  = 0;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0]      CONTROL_RESET = 8'h00;
  localparam logic [7:0]      COMMON_RESET  = 8'h00;
  localparam logic [15:0]     RELOAD_RESET  = 16'hffff;
  localparam logic [15:0]     CAPT_RESET    = 16'h0000;
  localparam logic [7:0]      SMR_KEEP_MASK = 8'h1c;
  localparam logic [15:0]     COUNT_MAX     = 16'hffff;

  // edge detector choices in demodulation mode
  localparam logic [1:0]      EDGE_FALL     = 2'b00;
  localparam logic [1:0]      EDGE_RISE     = 2'b01;
  localparam logic [1:0]      EDGE_BOTH     = 2'b10;

  // timer sequencing
  typedef enum logic [1:0] {st_idle, st_run, st_halted} timer_state_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction : byte_addr

endpackage : wide_timer_pkg

/* rtl/wide_timer_prescaler.sv */
// input clock prescaler for the wide timer: one tick pulse per divided period
`timescale 1ns/1ns
module wide_timer_prescaler
  import wide_timer_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] prescale_select,
  output logic            tick
);

  logic [2:0] div_q;
  logic [2:0] div_d;
  logic       tick_q;
  logic       tick_d;
  logic [2:0] limit;

  // ==========================================================================
  // divide by 1, 2, 4 or 8; restarts whenever the timer is stopped
  always_comb begin
    limit  = 3'((4'h1 << prescale_select) - 4'h1);
    div_d  = div_q;
    tick_d = 1'b0;
    if (!run) begin
      div_d = 3'h0;
    end else if (div_q >= limit) begin
      div_d  = 3'h0;
      tick_d = 1'b1;
    end else begin
      div_d = 3'(div_q + 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : wide_timer_prescaler

/* rtl/wide_timer_control.sv */
// wide timer control register, 16-bit counter, capture and pin routing
// ============================================================================
// What this block does
// - transmit mode: control bit 6 picks reload-and-continue or halt at terminal count
// - demodulation mode: count captured into low or high register on input edge
// - control bit 2 lets each capture raise a capture interrupt request
// - capture interrupt enable survives a stop mode recovery
// - control bit 1 lets terminal count raise a time-out interrupt request
// - control bit 0 routes timer output or port value to port 3 pin 5
// - common register bit 7: 0 transmit mode, 1 demodulation mode
// - while disabled the timer output sits at inverse of initial level
`timescale 1ns/1ns
module wide_timer_control
  import wide_timer_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              capture_pin,
  input  wire logic              smr_event,
  output logic                   port3_pin5,
  output logic                   wide_timer_output,
  output logic                   capture_irq,
  output logic                   timeout_irq
);

  // ==========================================================================
  // state
  logic [7:0]   ctl_q, ctl_d;
  logic [7:0]   cmn_q, cmn_d;
  logic [15:0]  reload_q, reload_d;
  logic [15:0]  capt_lo_q, capt_lo_d;
  logic [15:0]  capt_hi_q, capt_hi_d;
  logic         port_out_q, port_out_d;
  logic [15:0]  count_q, count_d;
  logic         out_q, out_d;
  logic         pin_q, pin_d;
  logic         cap_irq_q, cap_irq_d;
  logic         to_irq_q, to_irq_d;
  timer_state_t state_q, state_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         ready_q, ready_d;
  logic         err_q, err_d;
  logic         sync1_q, sync2_q, sync3_q;

  logic         wr_en;
  logic         setup;
  logic         tick;
  logic         demod;
  logic         rise;
  logic         fall;
  logic         cap_low;
  logic         cap_high;
  logic         tc;
  logic [1:0]   edge_sel;

  // ==========================================================================
  // address decode
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    is_reg = (a == byte_addr(idx));
  endfunction : is_reg

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = is_reg(a, IDX_COMMON)    || is_reg(a, IDX_CONTROL)   ||
             is_reg(a, IDX_RELOAD_LO) || is_reg(a, IDX_RELOAD_HI) ||
             is_reg(a, IDX_CAPT_LO)   || is_reg(a, IDX_CAPT_HI)   ||
             is_reg(a, IDX_PORT_OUT);
  endfunction : mapped

  // setup phase loads the answer; access phase then completes with no wait
  assign setup = psel && !penable;
  assign wr_en = psel && penable && ready_q && pwrite && !err_q;

  // ==========================================================================
  // capture pin synchroniser; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= capture_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign demod    = cmn_q[CMN_MODE];
  assign edge_sel = cmn_q[CMN_EDGE_HI:CMN_EDGE_LO];
  assign rise     = sync2_q && !sync3_q;
  assign fall     = !sync2_q && sync3_q;

  // reserved edge code captures nothing
  assign cap_high = demod && (state_q == st_run) && rise &&
                    (edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH);
  assign cap_low  = demod && (state_q == st_run) && fall &&
                    (edge_sel == EDGE_FALL || edge_sel == EDGE_BOTH);

  // ==========================================================================
  // prescaler
  wide_timer_prescaler u_prescaler (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (state_q == st_run),
    .prescale_select (ctl_q[CTL_PRESC_HI:CTL_PRESC_LO]),
    .tick            (tick)
  );

  // ==========================================================================
  // counter sequencing and output level
  always_comb begin
    state_d   = state_q;
    count_d   = count_q;
    out_d     = out_q;
    capt_lo_d = capt_lo_q;
    capt_hi_d = capt_hi_q;
    tc        = 1'b0;
    case (state_q)
      st_idle: begin
        out_d = !cmn_q[CMN_INIT_OUT];
        if (ctl_q[CTL_RUN]) begin
          state_d = st_run;
          count_d = demod ? 16'h0000 : reload_q;
          out_d   = cmn_q[CMN_INIT_OUT];
        end
      end
      st_run: begin
        if (!ctl_q[CTL_RUN]) begin
          state_d = st_idle;
          out_d   = !cmn_q[CMN_INIT_OUT];
        end else if (demod) begin
          // capture restarts the count so each value is one interval
          if (cap_low) begin
            capt_lo_d = count_q;
            count_d   = 16'h0000;
          end else if (cap_high) begin
            capt_hi_d = count_q;
            count_d   = 16'h0000;
          end else if (tick) begin
            count_d = 16'(count_q + 16'h0001);
            tc      = (count_q == COUNT_MAX);
          end
        end else if (tick) begin
          if (count_q == 16'h0000) begin
            tc    = 1'b1;
            out_d = !out_q;
            if (ctl_q[CTL_SINGLE]) begin
              state_d = st_halted;
            end else begin
              count_d = reload_q;
            end
          end else begin
            count_d = 16'(count_q - 16'h0001);
          end
        end
      end
      st_halted: begin
        // holds the last level until the run bit is cleared by software or by a stop mode recovery
        if (!ctl_q[CTL_RUN]) begin
          state_d = st_idle;
          out_d   = !cmn_q[CMN_INIT_OUT];
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  // ==========================================================================
  // software registers with hardware side effects
  always_comb begin
    ctl_d      = ctl_q;
    cmn_d      = cmn_q;
    reload_d   = reload_q;
    port_out_d = port_out_q;
    // stop mode recovery keeps prescale and capture enable only
    if (smr_event) begin
      ctl_d = ctl_q & SMR_KEEP_MASK;
    end
    if (wr_en && is_reg(paddr, IDX_CONTROL)) begin
      ctl_d = pwdata[7:0];
      ctl_d[CTL_TIMEOUT] = ctl_q[CTL_TIMEOUT] && !pwdata[CTL_TIMEOUT];
    end
    if (wr_en && is_reg(paddr, IDX_COMMON)) begin
      cmn_d = pwdata[7:0];
    end
    if (wr_en && is_reg(paddr, IDX_RELOAD_LO)) begin
      reload_d[7:0] = pwdata[7:0];
    end
    if (wr_en && is_reg(paddr, IDX_RELOAD_HI)) begin
      reload_d[15:8] = pwdata[7:0];
    end
    if (wr_en && is_reg(paddr, IDX_PORT_OUT)) begin
      port_out_d = pwdata[0];
    end
    // a terminal count in the same cycle as a clear still sets the flag
    if (tc) begin
      ctl_d[CTL_TIMEOUT] = 1'b1;
    end
  end

  // ==========================================================================
  // registered outputs: pin mux and interrupt request pulses
  always_comb begin
    pin_d     = ctl_q[CTL_PIN_SEL] ? out_q : port_out_q;
    cap_irq_d = (cap_low || cap_high) && ctl_q[CTL_CAP_IE];
    to_irq_d  = tc && ctl_q[CTL_TO_IE];
  end

  // ==========================================================================
  // bus answer prepared in the setup phase
  // error flag lives only in the access cycle so the port comes straight off it
  always_comb begin
    rdata_d = rdata_q;
    ready_d = 1'b0;
    err_d   = 1'b0;
    if (setup) begin
      ready_d = 1'b1;
      err_d   = !mapped(paddr);
      rdata_d = 32'h0000_0000;
      if (is_reg(paddr, IDX_CONTROL)) begin
        rdata_d[7:0] = ctl_q;
      end else if (is_reg(paddr, IDX_COMMON)) begin
        rdata_d[7:0] = cmn_q;
      end else if (is_reg(paddr, IDX_RELOAD_LO)) begin
        rdata_d[7:0] = reload_q[7:0];
      end else if (is_reg(paddr, IDX_RELOAD_HI)) begin
        rdata_d[7:0] = reload_q[15:8];
      end else if (is_reg(paddr, IDX_CAPT_LO)) begin
        rdata_d[15:0] = capt_lo_q;
      end else if (is_reg(paddr, IDX_CAPT_HI)) begin
        rdata_d[15:0] = capt_hi_q;
      end else if (is_reg(paddr, IDX_PORT_OUT)) begin
        rdata_d[0] = port_out_q;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q      <= CONTROL_RESET;
      cmn_q      <= COMMON_RESET;
      reload_q   <= RELOAD_RESET;
      capt_lo_q  <= CAPT_RESET;
      capt_hi_q  <= CAPT_RESET;
      port_out_q <= 1'b0;
      count_q    <= 16'h0000;
      out_q      <= 1'b1;
      pin_q      <= 1'b0;
      cap_irq_q  <= 1'b0;
      to_irq_q   <= 1'b0;
      state_q    <= st_idle;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
    end else begin
      ctl_q      <= ctl_d;
      cmn_q      <= cmn_d;
      reload_q   <= reload_d;
      capt_lo_q  <= capt_lo_d;
      capt_hi_q  <= capt_hi_d;
      port_out_q <= port_out_d;
      count_q    <= count_d;
      out_q      <= out_d;
      pin_q      <= pin_d;
      cap_irq_q  <= cap_irq_d;
      to_irq_q   <= to_irq_d;
      state_q    <= state_d;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
    end
  end

  assign prdata            = rdata_q;
  assign pready            = ready_q;
  assign pslverr           = err_q;
  assign port3_pin5        = pin_q;
  assign wide_timer_output = out_q;
  assign capture_irq       = cap_irq_q;
  assign timeout_irq       = to_irq_q;

endmodule : wide_timer_control

/* verification/wide_timer_control_properties.sv */
// port checker for the wide timer control block
`timescale 1ns/1ns
module wide_timer_control_properties
  import wide_timer_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              smr_event,
  input wire logic              port3_pin5,
  input wire logic              wide_timer_output,
  input wire logic              capture_irq,
  input wire logic              timeout_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // shadow of written bits; smr keeps only the surviving control bits
  logic [7:0] ctl_q, ctl_d, cmn_q, cmn_d;
  logic       port_q, port_d, wr, mapped;
  assign wr     = psel && penable && pready && pwrite && !pslverr;
  assign mapped = paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00 && paddr[13:2] inside
    {IDX_COMMON, IDX_CONTROL, IDX_RELOAD_LO, IDX_RELOAD_HI, IDX_CAPT_LO, IDX_CAPT_HI, IDX_PORT_OUT};
  always_comb begin
    ctl_d  = smr_event ? (ctl_q & SMR_KEEP_MASK) : ctl_q;
    cmn_d  = cmn_q;
    port_d = port_q;
    if (wr && paddr[13:2] == IDX_CONTROL) ctl_d = pwdata[7:0];
    if (wr && paddr[13:2] == IDX_COMMON) cmn_d = pwdata[7:0];
    if (wr && paddr[13:2] == IDX_PORT_OUT) port_d = pwdata[0];
  end
  // shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q  <= CONTROL_RESET;
      cmn_q  <= COMMON_RESET;
      port_q <= 1'b0;
    end else begin
      ctl_q  <= ctl_d;
      cmn_q  <= cmn_d;
      port_q <= port_d;
    end
  end
  // ==========================================================================
  // properties
  sequence s_setup; psel && !penable; endsequence
  sequence s_idle; !ctl_q[7] && !cmn_q[7] && $stable(cmn_q[0]); endsequence
  property p_ready_follows; s_setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_map; pready && !pwrite |-> pslverr == !mapped && (mapped || prdata == 0);
  endproperty
  property p_cap_pulse; capture_irq |=> !capture_irq; endproperty
  property p_to_pulse; timeout_irq |=> !timeout_irq; endproperty
  property p_cap_gate; capture_irq |-> $past(ctl_q[2]) || $past(ctl_q[2], 2); endproperty
  property p_to_gate; timeout_irq |-> $past(ctl_q[1]) || $past(ctl_q[1], 2); endproperty
  property p_pin_port; (!ctl_q[0])[*2] |-> port3_pin5 == $past(port_q); endproperty
  property p_idle_level; s_idle[*3] |-> wide_timer_output == !cmn_q[0]; endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("ready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_err_map: assert property (p_err_map) else $error("error response wrong");
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture irq too long");
  a_to_pulse: assert property (p_to_pulse) else $error("time-out irq too long");
  a_cap_gate: assert property (p_cap_gate) else $error("capture irq while masked");
  a_to_gate: assert property (p_to_gate) else $error("time-out irq while masked");
  a_pin_port: assert property (p_pin_port) else $error("pin not port value");
  a_idle_level: assert property (p_idle_level) else $error("idle output level wrong");
endmodule : wide_timer_control_properties

bind wide_timer_control wide_timer_control_properties wide_timer_control_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .smr_event, .port3_pin5, .wide_timer_output, .capture_irq, .timeout_irq);

/* verification/wide_timer_control_test.sv */
// self-checking bench for the wide timer control block
`timescale 1ns/1ns
module wide_timer_control_test import wide_timer_pkg::*;;
  localparam logic [15:0] A_CMN = {2'b00, IDX_COMMON, 2'b00};
  localparam logic [15:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [15:0] A_RLO = {2'b00, IDX_RELOAD_LO, 2'b00};
  localparam logic [15:0] A_RHI = {2'b00, IDX_RELOAD_HI, 2'b00};
  localparam logic [15:0] A_CLO = {2'b00, IDX_CAPT_LO, 2'b00};
  localparam logic [15:0] A_CHI = {2'b00, IDX_CAPT_HI, 2'b00};
  localparam logic [15:0] A_PRT = {2'b00, IDX_PORT_OUT, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic capture_pin = 1'b0, smr_event = 1'b0, er;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, port3_pin5, wide_timer_output, capture_irq, timeout_irq;
  int error_cnt = 0, checked = 0, to_cnt = 0, cap_cnt = 0;

  wide_timer_control wide_timer_control_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_pin, .smr_event, .port3_pin5,
    .wide_timer_output, .capture_irq, .timeout_irq);

  // ==========================================================================
  // clock and interrupt pulse counters
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (timeout_irq === 1'b1) to_cnt++;
    if (capture_irq === 1'b1) cap_cnt++;
  end

  // ==========================================================================
  // one apb transfer; releases only after ready is seen, watchdog bounds the wait
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // tests; a hang is cut short by the watchdog below
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctl reset", A_CTL, 32'h0);
    rdchk("cmn reset", A_CMN, 32'h0);
    xfer(16'h3500, 1'b0, 32'h0);
    chk("bad err", 32'h1, {31'h0, er});
    chk("bad data", 32'h0, rd);
    chk("idle out", 32'h1, {31'h0, wide_timer_output});
    xfer(A_CMN, 1'b1, 32'h01);
    wt(3);
    chk("idle inv", 32'h0, {31'h0, wide_timer_output});
    xfer(A_CMN, 1'b1, 32'h00);
    $display("test reset done");
    // pin routing both ways, port value differing from timer output in the last two checks
    xfer(A_PRT, 1'b1, 32'h01);
    wt(2);
    chk("pin port1", 32'h1, {31'h0, port3_pin5});
    xfer(A_PRT, 1'b1, 32'h00);
    xfer(A_CTL, 1'b1, 32'h01);
    wt(2);
    chk("pin timer", 32'h1, {31'h0, port3_pin5});
    xfer(A_CTL, 1'b1, 32'h00);
    wt(2);
    chk("pin port0", 32'h0, {31'h0, port3_pin5});
    $display("test pin done");
    // reload keeps counting, flag set then cleared by writing one
    xfer(A_RLO, 1'b1, 32'h02);
    xfer(A_RHI, 1'b1, 32'h00);
    to_cnt = 0;
    xfer(A_CTL, 1'b1, 32'h82);
    wt(20);
    xfer(A_CTL, 1'b1, 32'h02);
    chk("reloads", 32'h1, {31'h0, to_cnt >= 3});
    rdchk("flag kept", A_CTL, 32'h22);
    xfer(A_CTL, 1'b1, 32'h22);
    rdchk("flag clr", A_CTL, 32'h02);
    // single pass halts after one terminal count
    to_cnt = 0;
    xfer(A_CTL, 1'b1, 32'hc2);
    wt(30);
    chk("halt once", 32'h1, to_cnt);
    rdchk("halt ctl", A_CTL, 32'he2);
    // time-out flag still sets while the time-out interrupt is disabled
    xfer(A_CTL, 1'b1, 32'h20);
    to_cnt = 0;
    xfer(A_CTL, 1'b1, 32'h80);
    wt(12);
    xfer(A_CTL, 1'b1, 32'h00);
    chk("to masked", 32'h0, to_cnt);
    rdchk("flag masked", A_CTL, 32'h20);
    xfer(A_CTL, 1'b1, 32'h20);
    $display("test timer done");
    // demodulation captures on both edges, interrupt only when enabled
    xfer(A_CMN, 1'b1, 32'ha0);
    cap_cnt = 0;
    xfer(A_CTL, 1'b1, 32'h84);
    wt(6);
    capture_pin <= 1'b1;
    wt(10);
    chk("cap rise irq", 32'h1, cap_cnt);
    xfer(A_CHI, 1'b0, 32'h0);
    chk("cap high", 32'h1, {31'h0, rd != 0});
    capture_pin <= 1'b0;
    wt(10);
    chk("cap fall irq", 32'h2, cap_cnt);
    xfer(A_CLO, 1'b0, 32'h0);
    chk("cap low", 32'h1, {31'h0, rd != 0});
    xfer(A_CTL, 1'b1, 32'h80);
    capture_pin <= 1'b1;
    wt(10);
    chk("cap masked", 32'h2, cap_cnt);
    xfer(A_CTL, 1'b1, 32'h00);
    xfer(A_CMN, 1'b1, 32'h00);
    // transmit mode: pin edges capture nothing
    xfer(A_CTL, 1'b1, 32'h84);
    capture_pin <= 1'b0;
    wt(10);
    chk("tx no cap", 32'h2, cap_cnt);
    $display("test capture done");
    // stop mode recovery keeps prescale and capture enable only
    // stop first so no terminal count can land on the recovery cycle
    xfer(A_CTL, 1'b1, 32'h20);
    xfer(A_CTL, 1'b1, 32'h9f);
    smr_event <= 1'b1;
    @(posedge pclk);
    smr_event <= 1'b0;
    rdchk("smr keep", A_CTL, 32'h1c);
    $display("test recovery done");
    give_verdict();
  end

  // watchdog well past the few hundred cycles the tests need
  initial begin
    #50000;
    error_cnt++;
    give_verdict();
  end
endmodule : wide_timer_control_test
